// File: rtl/pcw_window_config.sv
// pcw_window_config: window enable, io window control and io window address registers
// of one 16-bit card socket, with the claim decision for host memory and io cycles
// assumes a byte register port on offsets of the socket register space, a one-cycle
// cycle strobe from the host bus and memory address matches made outside this block
//
// Summary of operation
// - disabled window never claims a host cycle
// - enable bits 7,6 open io windows 1,0
// - enable bits 4..0 open memory windows 4..0
// - enable bit 5 reads zero, ignores writes
// - long bit adds wait to 16-bit io
// - short bit trims 8-bit io to three
// - dynamic bit takes width from card signal
// - fixed bit picks 8 or 16 bits
// - start address low bytes at 08h, 0Ch
// - start address high bytes at 09h, 0Dh
// - each register also at base plus 800h
// - io control register read/write, resets zero
// - end addresses at 0Ah/0Bh and 0Eh/0Fh
`timescale 1ns/1ps
`default_nettype none
module pcw_window_config
    import pcw_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // register port
    input wire logic [11:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // host cycle toward the card
    input wire logic cyc_start,
    input wire logic cyc_io,
    input wire logic [15:0] cyc_addr,
    input wire logic [MEM_WINDOWS-1:0] mem_match,
    input wire logic card_iois16,
    // claim decision
    output logic claim,
    output logic claim_io,
    output logic claim_mem,
    output logic claim_io_win,
    output logic [MEM_WINDOWS-1:0] claim_mem_win,
    output logic io_width16,
    output logic io_long_cycle,
    output logic io_short_cycle,
    // current enables for the memory window decoders
    output logic [MEM_WINDOWS-1:0] mem_window_on
);

    typedef struct packed {
        logic [7:0] win_en;
        logic [7:0] io_ctrl;
        logic [15:0] io0_start;
        logic [15:0] io0_end;
        logic [15:0] io1_start;
        logic [15:0] io1_end;
        logic [7:0] rdata;
        logic rvalid;
        logic claim;
        logic claim_io;
        logic claim_mem;
        logic claim_io_win;
        logic [MEM_WINDOWS-1:0] claim_mem_win;
        logic width16;
        logic long_cyc;
        logic short_cyc;
    } pcw_state_t;

    pcw_state_t state_reg;
    pcw_state_t state_next;

    logic view_ok;
    logic [7:0] idx;
    logic acc_wr;
    logic acc_rd;
    logic [7:0] rd_mux;
    logic [MEM_WINDOWS-1:0] mem_hit;
    logic view_compat;
    logic view_ext;
    logic io_any_hit;
    logic mem_any_hit;

    logic hit0;
    logic hit1;
    logic w16_0;
    logic w16_1;
    logic long0;
    logic long1;
    logic short0;
    logic short1;

    // both views land on the same storage
    assign view_compat = (reg_addr[11:8] == VIEW_COMPAT);
    assign view_ext = (reg_addr[11:8] == VIEW_EXT);
    assign view_ok = view_compat || view_ext;
    assign idx = reg_addr[7:0];
    assign acc_wr = reg_wr && view_ok;
    assign acc_rd = reg_rd && view_ok;

    // io window 0
    pcw_io_match u_io0 (
        .on(state_reg.win_en[IO_WINDOW_ZERO_ON]),
        .ctrl(state_reg.io_ctrl[IO_ZERO_LONG_CYCLE:IO_ZERO_FIXED_WIDTH]),
        .start_addr(state_reg.io0_start),
        .end_addr(state_reg.io0_end),
        .addr(cyc_addr),
        .card_iois16(card_iois16),
        .hit(hit0),
        .width16(w16_0),
        .long_cyc(long0),
        .short_cyc(short0)
    );

    // io window 1
    pcw_io_match u_io1 (
        .on(state_reg.win_en[IO_WINDOW_ONE_ON]),
        .ctrl(state_reg.io_ctrl[IO_ONE_LONG_CYCLE:IO_ONE_FIXED_WIDTH]),
        .start_addr(state_reg.io1_start),
        .end_addr(state_reg.io1_end),
        .addr(cyc_addr),
        .card_iois16(card_iois16),
        .hit(hit1),
        .width16(w16_1),
        .long_cyc(long1),
        .short_cyc(short1)
    );

    // memory matches pass only through enabled windows
    assign mem_hit = mem_match & state_reg.win_en[MEM_WINDOW_FOUR_ON:MEM_WINDOW_ZERO_ON];

    // claim summary of each side
    assign io_any_hit = hit0 || hit1;
    assign mem_any_hit = |mem_hit;

    // read data selection
    always_comb begin
        rd_mux = 8'h00;
        unique case (idx)
            IDX_WINDOW_ENABLE: begin
                rd_mux = state_reg.win_en & WIN_EN_WMASK;
            end
            IDX_IO_WINDOW_CONTROL: begin
                rd_mux = state_reg.io_ctrl;
            end
            IDX_IO_WIN0_START_LOW: begin
                rd_mux = state_reg.io0_start[7:0];
            end
            IDX_IO_WIN0_START_HIGH: begin
                rd_mux = state_reg.io0_start[15:8];
            end
            IDX_IO_WIN0_END_LOW: begin
                rd_mux = state_reg.io0_end[7:0];
            end
            IDX_IO_WIN0_END_HIGH: begin
                rd_mux = state_reg.io0_end[15:8];
            end
            IDX_IO_WIN1_START_LOW: begin
                rd_mux = state_reg.io1_start[7:0];
            end
            IDX_IO_WIN1_START_HIGH: begin
                rd_mux = state_reg.io1_start[15:8];
            end
            IDX_IO_WIN1_END_LOW: begin
                rd_mux = state_reg.io1_end[7:0];
            end
            IDX_IO_WIN1_END_HIGH: begin
                rd_mux = state_reg.io1_end[15:8];
            end
            default: begin
                // unmapped index reads zero
                rd_mux = 8'h00;
            end
        endcase
    end

    // next state
    always_comb begin
        state_next = state_reg;
        state_next.rvalid = 1'b0;

        // register writes
        if (acc_wr) begin
            unique case (idx)
                IDX_WINDOW_ENABLE: begin
                    // reserved bit stays zero
                    state_next.win_en = reg_wdata & WIN_EN_WMASK;
                end
                IDX_IO_WINDOW_CONTROL: begin
                    state_next.io_ctrl = reg_wdata;
                end
                IDX_IO_WIN0_START_LOW: begin
                    state_next.io0_start[7:0] = reg_wdata;
                end
                IDX_IO_WIN0_START_HIGH: begin
                    state_next.io0_start[15:8] = reg_wdata;
                end
                IDX_IO_WIN0_END_LOW: begin
                    state_next.io0_end[7:0] = reg_wdata;
                end
                IDX_IO_WIN0_END_HIGH: begin
                    state_next.io0_end[15:8] = reg_wdata;
                end
                IDX_IO_WIN1_START_LOW: begin
                    state_next.io1_start[7:0] = reg_wdata;
                end
                IDX_IO_WIN1_START_HIGH: begin
                    state_next.io1_start[15:8] = reg_wdata;
                end
                IDX_IO_WIN1_END_LOW: begin
                    state_next.io1_end[7:0] = reg_wdata;
                end
                IDX_IO_WIN1_END_HIGH: begin
                    state_next.io1_end[15:8] = reg_wdata;
                end
                default: begin
                    // writes to unmapped indices are dropped
                    state_next.win_en = state_reg.win_en;
                end
            endcase
        end

        // register reads, data one cycle later
        if (reg_rd) begin
            state_next.rvalid = 1'b1;
            if (acc_rd) begin
                state_next.rdata = rd_mux;
            end else begin
                // unmapped view reads zero
                state_next.rdata = 8'h00;
            end
        end

        // claim decision, held until the next cycle strobe
        if (cyc_start) begin
            state_next.claim_io = 1'b0;
            state_next.claim_mem = 1'b0;
            state_next.claim_io_win = 1'b0;
            state_next.claim_mem_win = '0;
            state_next.width16 = 1'b0;
            state_next.long_cyc = 1'b0;
            state_next.short_cyc = 1'b0;
            if (cyc_io) begin
                // window 0 wins when both windows overlap
                if (hit0) begin
                    state_next.claim_io = 1'b1;
                    state_next.claim_io_win = 1'b0;
                    state_next.width16 = w16_0;
                    state_next.long_cyc = long0;
                    state_next.short_cyc = short0;
                end else if (hit1) begin
                    state_next.claim_io = 1'b1;
                    state_next.claim_io_win = 1'b1;
                    state_next.width16 = w16_1;
                    state_next.long_cyc = long1;
                    state_next.short_cyc = short1;
                end
            end else begin
                state_next.claim_mem = mem_any_hit;
                state_next.claim_mem_win = mem_hit;
            end
            if (cyc_io) begin
                state_next.claim = io_any_hit;
            end else begin
                state_next.claim = mem_any_hit;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg <= '0;
            state_reg.win_en <= RST_WINDOW_ENABLE;
            state_reg.io_ctrl <= RST_IO_WINDOW_CONTROL;
            state_reg.io0_start <= RST_IO_ADDR;
            state_reg.io0_end <= RST_IO_ADDR;
            state_reg.io1_start <= RST_IO_ADDR;
            state_reg.io1_end <= RST_IO_ADDR;
            state_reg.rdata <= RST_RDATA;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs
    assign reg_rdata = state_reg.rdata;
    assign reg_rvalid = state_reg.rvalid;
    assign claim = state_reg.claim;
    assign claim_io = state_reg.claim_io;
    assign claim_mem = state_reg.claim_mem;
    assign claim_io_win = state_reg.claim_io_win;
    assign claim_mem_win = state_reg.claim_mem_win;
    assign io_width16 = state_reg.width16;
    assign io_long_cycle = state_reg.long_cyc;
    assign io_short_cycle = state_reg.short_cyc;
    assign mem_window_on = state_reg.win_en[MEM_WINDOW_FOUR_ON:MEM_WINDOW_ZERO_ON];

endmodule : pcw_window_config
`default_nettype wire

// File: rtl/pcw_pkg.sv
// pcw_pkg: register map, field positions and reset values of the socket window configuration
// assumes a byte-wide register port addressed by a 12-bit socket register offset
package pcw_pkg;

    // register indices, reachable at the index itself and at 800h + index (VIEW_EXT upper nibble)
    localparam logic [7:0] IDX_WINDOW_ENABLE = 8'h06;
    localparam logic [7:0] IDX_IO_WINDOW_CONTROL = 8'h07;
    localparam logic [7:0] IDX_IO_WIN0_START_LOW = 8'h08;
    localparam logic [7:0] IDX_IO_WIN0_START_HIGH = 8'h09;
    localparam logic [7:0] IDX_IO_WIN0_END_LOW = 8'h0a;
    localparam logic [7:0] IDX_IO_WIN0_END_HIGH = 8'h0b;
    localparam logic [7:0] IDX_IO_WIN1_START_LOW = 8'h0c;
    localparam logic [7:0] IDX_IO_WIN1_START_HIGH = 8'h0d;
    localparam logic [7:0] IDX_IO_WIN1_END_LOW = 8'h0e;
    localparam logic [7:0] IDX_IO_WIN1_END_HIGH = 8'h0f;

    // upper nibble of the 12-bit offset: plain view and extended view
    localparam logic [3:0] VIEW_COMPAT = 4'h0;
    localparam logic [3:0] VIEW_EXT = 4'h8;

    // window enable register fields
    localparam int IO_WINDOW_ONE_ON = 7;
    localparam int IO_WINDOW_ZERO_ON = 6;
    localparam int WIN_EN_RSVD = 5;
    localparam int MEM_WINDOW_FOUR_ON = 4;
    localparam int MEM_WINDOW_ZERO_ON = 0;
    localparam int MEM_WINDOWS = 5;
    localparam logic [7:0] WIN_EN_WMASK = 8'hdf;

    // io window control fields
    localparam int IO_ONE_LONG_CYCLE = 7;
    localparam int IO_ONE_SHORT_CYCLE = 6;
    localparam int IO_ONE_DYNAMIC_WIDTH = 5;
    localparam int IO_ONE_FIXED_WIDTH = 4;
    localparam int IO_ZERO_LONG_CYCLE = 3;
    localparam int IO_ZERO_SHORT_CYCLE = 2;
    localparam int IO_ZERO_DYNAMIC_WIDTH = 1;
    localparam int IO_ZERO_FIXED_WIDTH = 0;

    // position of the fields inside one window's control nibble
    localparam int NIB_LONG = 3;
    localparam int NIB_SHORT = 2;
    localparam int NIB_DYNAMIC = 1;
    localparam int NIB_FIXED = 0;

    // reset values
    localparam logic [7:0] RST_WINDOW_ENABLE = 8'h00;
    localparam logic [7:0] RST_IO_WINDOW_CONTROL = 8'h00;
    localparam logic [15:0] RST_IO_ADDR = 16'h0000;
    localparam logic [7:0] RST_RDATA = 8'h00;

endpackage : pcw_pkg

// File: rtl/pcw_io_match.sv
// pcw_io_match: address match and cycle shaping for one io window
// assumes the control nibble of its window and a card width strobe valid with the cycle
`timescale 1ns/1ps
`default_nettype none
module pcw_io_match
    import pcw_pkg::*;
(
    // window setup
    input wire logic on,
    input wire logic [3:0] ctrl,
    input wire logic [15:0] start_addr,
    input wire logic [15:0] end_addr,
    // cycle
    input wire logic [15:0] addr,
    input wire logic card_iois16,
    // result
    output logic hit,
    output logic width16,
    output logic long_cyc,
    output logic short_cyc
);

    always_comb begin
        // no hit without the enable, whatever the address registers hold
        hit = on && (addr >= start_addr) && (addr <= end_addr);
        // dynamic sizing overrides the fixed width bit
        width16 = ctrl[NIB_DYNAMIC] ? card_iois16 : ctrl[NIB_FIXED];
        // extra wait applies to 16-bit cycles only
        long_cyc = width16 && ctrl[NIB_LONG];
        // zero wait applies to 8-bit cycles only
        short_cyc = !width16 && ctrl[NIB_SHORT];
    end

endmodule : pcw_io_match
`default_nettype wire

// File: verification/pcw_window_config_properties.sv
// pcw_window_config_properties: port checks of the window configuration block
// assumes it is bound to pcw_window_config and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module pcw_window_config_properties
    import pcw_pkg::*;
(
    // clock, reset, register port
    input wire logic clk,
    input wire logic srst,
    input wire logic [11:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    // host cycle and decision
    input wire logic cyc_start,
    input wire logic cyc_io,
    input wire logic [MEM_WINDOWS-1:0] mem_match,
    input wire logic claim,
    input wire logic claim_io,
    input wire logic claim_mem,
    input wire logic [MEM_WINDOWS-1:0] claim_mem_win,
    input wire logic io_width16,
    input wire logic io_long_cycle,
    input wire logic io_short_cycle,
    input wire logic [MEM_WINDOWS-1:0] mem_window_on
);
    logic [7:0] wd_q;
    logic [11:0] ra_q;
    logic [4:0] mm_q;
    logic [1:0] io_on;
    logic en_wr;
    assign en_wr = reg_wr && reg_addr[7:0] == IDX_WINDOW_ENABLE
        && (reg_addr[11:8] == VIEW_COMPAT || reg_addr[11:8] == VIEW_EXT);
    // shadow of the io enables, kept only to judge claims
    always_ff @(posedge clk) begin
        wd_q <= reg_wdata;
        ra_q <= reg_addr;
        mm_q <= mem_match & mem_window_on;
        if (srst) begin
            io_on <= 2'h0;
        end else if (en_wr) begin
            io_on <= reg_wdata[7:6];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    AST_RVALID: assert property (reg_rvalid == $past(reg_rd))
        else $error("read answer not one cycle after request");
    AST_RSVD_ZERO: assert property (reg_rvalid && ra_q[7:0] == IDX_WINDOW_ENABLE |->
        reg_rdata[WIN_EN_RSVD] == 1'b0) else $error("reserved enable bit reads one");
    AST_UNMAPPED: assert property (reg_rvalid && ra_q[11:8] != VIEW_COMPAT
        && ra_q[11:8] != VIEW_EXT |-> reg_rdata == 8'h00) else $error("unmapped read not zero");
    AST_MEM_ON: assert property (en_wr |=> mem_window_on == wd_q[4:0])
        else $error("memory enables not taken from write");
    AST_IO_OFF: assert property (cyc_start && cyc_io && io_on == 2'h0 |=>
        !claim_io && !claim) else $error("io cycle claimed with io windows off");
    AST_MEM_CLAIM: assert property (cyc_start && !cyc_io |=> claim_mem_win == mm_q
        && claim_mem == (mm_q != 5'h00)) else $error("memory claim not gated by enables");
    AST_LONG16: assert property (io_long_cycle |-> io_width16 && claim_io)
        else $error("long cycle on non 16-bit transfer");
    AST_SHORT8: assert property (io_short_cycle |-> !io_width16 && claim_io)
        else $error("short cycle on non 8-bit transfer");
    AST_HOLD: assert property (!cyc_start |=> $stable(claim) && $stable(claim_mem_win))
        else $error("claim changed without a cycle");
    cover property (cyc_start && cyc_io ##1 claim_io);
    cover property (cyc_start && !cyc_io ##1 claim_mem);
    cover property (reg_rvalid && ra_q[11:8] == 4'h4);
endmodule : pcw_window_config_properties
bind pcw_window_config pcw_window_config_properties i_props (.clk, .srst, .reg_addr,
    .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid, .cyc_start, .cyc_io, .mem_match,
    .claim, .claim_io, .claim_mem, .claim_mem_win, .io_width16, .io_long_cycle,
    .io_short_cycle, .mem_window_on);
`default_nettype wire

// File: verification/pcw_card_model.sv
// pcw_card_model: 16-bit card that reports its transfer width per io address
// assumes the host io address is held while the cycle strobe is high
`timescale 1ns/1ps
`default_nettype none
module pcw_card_model (
    // host side
    input wire logic [15:0] addr,
    // card signal
    output logic iois16
);
    // upper half of each 16-byte bank is a 16-bit register block
    assign iois16 = addr[3];
endmodule : pcw_card_model
`default_nettype wire

// File: verification/tb.sv
// tb: register and host cycle tests of pcw_window_config
// assumes the card model drives the width signal from the cycle address
`timescale 1ns/1ps
`default_nettype none
module tb;
    import pcw_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [11:0] reg_addr = 12'h000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic cyc_start = 1'b0;
    logic cyc_io = 1'b0;
    logic [15:0] cyc_addr = 16'h0000;
    logic [4:0] mem_match = 5'h00;
    logic card_iois16, reg_rvalid, claim, claim_io, claim_mem, claim_io_win;
    logic io_width16, io_long_cycle, io_short_cycle;
    logic [7:0] reg_rdata;
    logic [4:0] claim_mem_win, mem_window_on;
    int n_fail = 0;
    int check_count = 0;
    logic [11:0] idx [8] = '{12'h006, 12'h007, 12'h008, 12'h009, 12'h00c, 12'h00d,
        12'h80a, 12'h80f};
    logic [19:0] setup [8] = '{20'h00800, 20'h00903, 20'h00a0f, 20'h00b03, 20'h00c0c,
        20'h00d03, 20'h00e20, 20'h00f03};
    logic [3:0] tc [8] = '{4'h0, 4'h4, 4'h9, 4'hc, 4'h5, 4'hb, 4'h2, 4'ha};
    logic [15:0] ta [8] = '{16'h0305, 16'h0305, 16'h0305, 16'h0300, 16'h030f, 16'h0305,
        16'h030a, 16'h030a};
    logic [2:0] te [8] = '{3'h0, 3'h1, 3'h6, 3'h1, 3'h4, 3'h0, 3'h4, 3'h6};
    pcw_window_config i_dut (.clk, .srst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
        .reg_rdata, .reg_rvalid, .cyc_start, .cyc_io, .cyc_addr, .mem_match, .card_iois16,
        .claim, .claim_io, .claim_mem, .claim_io_win, .claim_mem_win, .io_width16,
        .io_long_cycle, .io_short_cycle, .mem_window_on);
    pcw_card_model i_card (.addr(cyc_addr), .iois16(card_iois16));
    initial begin
        forever #12.5 clk = ~clk;
    end
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    // read answers exactly one cycle after the request edge
    task automatic rdc(input logic [11:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        check({3'h0, reg_rvalid, reg_rdata}, {4'h1, e});
    endtask : rdc
    task automatic cyc(input logic io, input logic [15:0] a, input logic [4:0] mm,
            input logic [11:0] e);
        @(posedge clk);
        cyc_start <= 1'b1;
        cyc_io <= io;
        cyc_addr <= a;
        mem_match <= mm;
        @(posedge clk);
        cyc_start <= 1'b0;
        #1;
        check({claim, claim_io, claim_mem, claim_io_win, io_width16, io_long_cycle,
            io_short_cycle, claim_mem_win}, e);
    endtask : cyc
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (4000) @(posedge clk);
        n_fail++;
        end_of_test();
    end
    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        foreach (idx[i]) rdc(idx[i], 8'h00);
        $display("test 1 done");
        wr(12'h806, 8'hff);
        rdc(12'h006, 8'hdf);
        check({7'h0, mem_window_on}, 12'h01f);
        wr(12'h007, 8'ha5);
        rdc(12'h807, 8'ha5);
        for (int i = 2; i < 8; i++) wr(idx[i] ^ 12'h800, 8'(8'ha0 + i));
        for (int i = 2; i < 8; i++) rdc(idx[i], 8'(8'ha0 + i));
        wr(12'h406, 8'h00);
        rdc(12'h406, 8'h00);
        rdc(12'h006, 8'hdf);
        $display("test 2 done");
        foreach (setup[i]) wr(setup[i][19:8], setup[i][7:0]);
        wr(12'h006, 8'h00);
        cyc(1'b1, 16'h0305, 5'h00, 12'h000);
        cyc(1'b0, 16'h0000, 5'h1f, 12'h000);
        wr(12'h006, 8'h5f);
        foreach (tc[i]) begin
            wr(12'h007, {4'h0, tc[i]});
            cyc(1'b1, ta[i], 5'h00, {4'hc, te[i], 5'h00});
        end
        cyc(1'b1, 16'h02ff, 5'h00, 12'h000);
        cyc(1'b1, 16'h0310, 5'h00, 12'h000);
        $display("test 3 done");
        wr(12'h006, 8'hc3);
        wr(12'h007, 8'h90);
        cyc(1'b1, 16'h0310, 5'h00, {4'hd, 3'h6, 5'h00});
        cyc(1'b1, 16'h030c, 5'h00, {4'hc, 3'h0, 5'h00});
        cyc(1'b0, 16'h0000, 5'h1f, {4'ha, 3'h0, 5'h03});
        cyc(1'b0, 16'h0000, 5'h1c, 12'h000);
        $display("test 4 done");
        @(posedge clk);
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        rdc(12'h006, 8'h00);
        rdc(12'h80d, 8'h00);
        wr(12'h006, 8'h20);
        rdc(12'h006, 8'h00);
        $display("test 5 done");
        end_of_test();
    end
endmodule : tb
`default_nettype wire
